// ---- pkg/dhp_pkg.sv ----
package dhp_pkg;

  // Data path
  localparam int DATA_W = 8;
  localparam int SECTOR_BYTES = 256;
  localparam int BUF_AW = 8;
  localparam logic [7:0] SECTOR_LAST = 8'hFF;
  localparam int LBA_W = 21;

  // Command descriptor lengths and classes
  localparam logic [3:0] CMD_LEN_SHORT = 4'h6;
  localparam logic [3:0] CMD_LEN_LONG = 4'hA;
  localparam logic [2:0] CLASS_BASE = 3'h0;
  localparam logic [2:0] CLASS_COPY = 3'h1;
  localparam int CLASS_MSB = 7;
  localparam int CLASS_LSB = 5;
  localparam logic [4:0] OP_READ = 5'h08;
  localparam logic [4:0] OP_WRITE = 5'h0A;

  // Completion status byte layout
  localparam int STS_PAR_BIT = 0;
  localparam int STS_EXE_BIT = 1;
  localparam int STS_LUN_LSB = 5;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_MAX_NS = 1000;
  localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int RST_MIN_NS = 250;
  localparam int RST_MAX_NS = 10000;

  // Handshake steps for one byte
  localparam logic [2:0] HS_PREP = 3'h0;
  localparam logic [2:0] HS_LOAD = 3'h1;
  localparam logic [2:0] HS_REQ = 3'h2;
  localparam logic [2:0] HS_ACK = 3'h3;
  localparam logic [2:0] HS_REL = 3'h4;

  // Controller phases
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SELECT = 4'h1,
    ST_CMD = 4'h2,
    ST_EXEC = 4'h3,
    ST_HOST_IN = 4'h4,
    ST_DISK_OUT = 4'h5,
    ST_DISK_IN = 4'h6,
    ST_HOST_OUT = 4'h7,
    ST_STATUS = 4'h8,
    ST_DONE = 4'h9
  } dhp_state_t;

  // Odd parity bit over one byte
  function automatic logic odd_par(input logic [7:0] d);
    return ~(^d);
  endfunction : odd_par

endpackage : dhp_pkg

// ---- pkg/dhp_buf_if.sv ----
`timescale 1ns/1ps
interface dhp_buf_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  // Port control side and memory side
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : dhp_buf_if

// ---- rtl/dhp_sector_buf.sv ----
`timescale 1ns/1ps
module dhp_sector_buf #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_sys_i,
  // Buffer access
  dhp_buf_if.mem bus
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_q;

  // Array has no reset; contents are always written before they are read
  always_ff @(posedge clk_sys_i) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    rd_q <= mem[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;
endmodule : dhp_sector_buf

// ---- rtl/dhp_host_port.sv ----
// Contract
// R1 - Host selects first; idle controller then requests command
// R2 - Up to ten command bytes, then execute
// R3 - Transfer address beyond drive limit flags error
// R4 - All transfer data staged in sector buffer
// R5 - Every sector is exactly 256 bytes
// R6 - Completion status returned when command finishes
// R7 - Odd parity on every driven byte
// R8 - Bad received parity flagged, checking can be disabled
// R9 - Active-low lines; controller paces every transfer
// R10 - Direction line decides who drives data
// R11 - Command/data line asserted only for command bytes; the code also asserts it for the status and message bytes
// R12 - Busy answers select, held while bus owned
// R13 - Message only at done, with direction and request
// R14 - Phase encoding by direction, command/data, message
// R15 - Request with direction tells who presents byte
// R16 - Host answers each request with one acknowledge
// R17 - Host reset restarts controller, drops disk outputs
// R18 - Pending error status lost after reset
// R19 - Host holds reset between 250 ns and 10 us
// R20 - Host puts select bit up with select
// R21 - Busy within one microsecond of valid select
// R22 - Host releases select once busy seen
// R23 - Zero message byte, then release everything after acknowledge
// R24 - Status: parity, execution error, zeros, unit number
// R25 - Six bytes for classes 0/7, ten for 1
// R26 - Fully interlocked request/acknowledge per byte
// R27 - Host latches controller byte before acknowledging
`timescale 1ns/1ps
module dhp_host_port #(
  parameter int SEL_ID_BIT = 0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Host bus control, pin levels
  input wire logic host_sel_n_i,
  input wire logic host_ack_n_i,
  input wire logic host_rst_n_i,
  output logic host_busy_n_o,
  output logic host_io_n_o,
  output logic host_cd_n_o,
  output logic host_msg_n_o,
  output logic host_req_n_o,
  // Host bus data, pin levels
  input wire logic [7:0] host_data_i,
  input wire logic host_par_i,
  output logic [7:0] host_data_o,
  output logic host_par_o,
  output logic host_data_oe_n_o,
  // Configuration
  input wire logic parity_en_i,
  input wire logic [dhp_pkg::LBA_W-1:0] max_lba_i,
  // Command hand-off to execution logic
  output logic cmd_start_o,
  output logic [7:0] cmd_opcode_o,
  output logic [2:0] cmd_lun_o,
  output logic [dhp_pkg::LBA_W-1:0] cmd_lba_o,
  output logic [7:0] cmd_nblk_o,
  input wire logic exec_done_i,
  input wire logic exec_err_i,
  output logic err_pending_o,
  // Disk-side byte streams
  output logic [7:0] disk_tx_data_o,
  output logic disk_tx_valid_o,
  input wire logic disk_tx_ready_i,
  input wire logic [7:0] disk_rx_data_i,
  input wire logic disk_rx_valid_i,
  output logic disk_rx_ready_o
);

  typedef struct packed {
    logic [1:0] sel_s;
    logic [1:0] ack_s;
    logic [1:0] rst_s;
    logic [8:0] dat_s1;
    logic [8:0] dat_s2;
    dhp_pkg::dhp_state_t state;
    logic [2:0] hs;
    logic [7:0] cnt;
    logic [3:0] cmd_len;
    logic [7:0] blk_left;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] blk;
    logic par_err;
    logic exe_err;
    logic err_pending;
    logic busy_n;
    logic io_n;
    logic cd_n;
    logic msg_n;
    logic req_n;
    logic oe_n;
    logic [7:0] dout_n;
    logic par_n;
    logic cmd_start;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rx_ready;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } dhp_port_st_t;

  localparam dhp_port_st_t ST_RST = '{
    sel_s: 2'h3, ack_s: 2'h3, rst_s: 2'h3, dat_s1: 9'h1FF, dat_s2: 9'h1FF,
    state: dhp_pkg::ST_IDLE, busy_n: 1'b1, io_n: 1'b1, cd_n: 1'b1, msg_n: 1'b1,
    req_n: 1'b1, oe_n: 1'b1, dout_n: 8'hFF, par_n: 1'b1, default: '0};

  dhp_port_st_t st;
  dhp_port_st_t next_st;

  logic hrst;
  logic sel;
  logic ack;
  logic [7:0] din;
  logic dpar;
  logic in_hs;
  logic hs_cap;
  logic hs_end;
  logic rx_par_bad;
  logic is_data;
  logic out_of_range;
  logic [7:0] status_byte;
  logic [7:0] src_byte;
  logic [dhp_pkg::LBA_W:0] lba_end;
  logic [dhp_pkg::LBA_W:0] lba_lim;

  dhp_buf_if #(.AW(dhp_pkg::BUF_AW), .DW(dhp_pkg::DATA_W)) buf_if ();

  dhp_sector_buf #(.AW(dhp_pkg::BUF_AW), .DW(dhp_pkg::DATA_W)) u_buf (
    .clk_sys_i(clk_sys_i),
    .bus(buf_if)
  );

  // Buffer access driven from registered state only
  assign buf_if.wr_en = st.wr_en; // R4
  assign buf_if.wr_addr = st.wr_addr;
  assign buf_if.wr_data = st.wr_data;
  assign buf_if.rd_addr = st.cnt;

  // Decoded synchronised host lines; bus is negative logic
  assign hrst = ~st.rst_s[1];
  assign sel = ~st.sel_s[1];
  assign ack = ~st.ack_s[1];
  assign din = ~st.dat_s2[7:0]; // R9
  assign dpar = ~st.dat_s2[8];
  assign rx_par_bad = parity_en_i & ~(^{din, dpar}); // R8

  // Byte handshake events
  assign in_hs = (st.state == dhp_pkg::ST_CMD) || (st.state == dhp_pkg::ST_HOST_IN) ||
                 (st.state == dhp_pkg::ST_HOST_OUT) || (st.state == dhp_pkg::ST_STATUS) ||
                 (st.state == dhp_pkg::ST_DONE);
  assign hs_cap = (st.hs == dhp_pkg::HS_ACK) && ack;
  assign hs_end = (st.hs == dhp_pkg::HS_REL) && !ack;

  // Command decode and drive-limit check
  assign is_data = (st.op[dhp_pkg::CLASS_MSB:dhp_pkg::CLASS_LSB] == dhp_pkg::CLASS_BASE) &&
                   ((st.op[4:0] == dhp_pkg::OP_READ) || (st.op[4:0] == dhp_pkg::OP_WRITE));
  assign lba_end = {1'b0, st.b1[4:0], st.b2, st.b3} + {14'h0000, st.blk};
  assign lba_lim = {1'b0, max_lba_i} + 22'h000001;
  assign out_of_range = lba_end > lba_lim; // R3

  // Completion status: unit number on top, spare bits zero
  always_comb begin
    status_byte = 8'h00; // R24
    status_byte[dhp_pkg::STS_PAR_BIT] = st.par_err;
    status_byte[dhp_pkg::STS_EXE_BIT] = st.exe_err;
    status_byte[dhp_pkg::STS_LUN_LSB +: 3] = st.b1[7:5];
  end

  // Byte the controller presents in the current phase; zero for the done message
  assign src_byte = (st.state == dhp_pkg::ST_HOST_OUT) ? buf_if.rd_data :
                    (st.state == dhp_pkg::ST_STATUS) ? status_byte : 8'h00; // R23

  // Next-state logic for the whole port
  always_comb begin
    next_st = st;
    next_st.sel_s = {st.sel_s[0], host_sel_n_i};
    next_st.ack_s = {st.ack_s[0], host_ack_n_i};
    next_st.rst_s = {st.rst_s[0], host_rst_n_i};
    next_st.dat_s1 = {host_par_i, host_data_i};
    next_st.dat_s2 = st.dat_s1;
    next_st.cmd_start = 1'b0;
    next_st.wr_en = 1'b0;
    // Execution errors stick for the rest of the command
    if (!st.busy_n && exec_err_i) begin
      next_st.exe_err = 1'b1;
    end
    if (hrst) begin
      // Back to the start with every line and disk output released
      next_st.state = dhp_pkg::ST_IDLE; // R17
      next_st.hs = dhp_pkg::HS_PREP;
      next_st.busy_n = 1'b1;
      next_st.io_n = 1'b1;
      next_st.cd_n = 1'b1;
      next_st.msg_n = 1'b1;
      next_st.req_n = 1'b1;
      next_st.oe_n = 1'b1;
      next_st.dout_n = 8'hFF;
      next_st.par_n = 1'b1;
      next_st.tx_valid = 1'b0; // R17
      next_st.rx_ready = 1'b0;
      next_st.par_err = 1'b0;
      next_st.exe_err = 1'b0;
      next_st.err_pending = 1'b0; // R18
    end else begin
      // Generic interlocked byte handshake paced by the controller
      if (in_hs) begin
        case (st.hs)
          dhp_pkg::HS_PREP: next_st.hs = dhp_pkg::HS_LOAD;
          dhp_pkg::HS_LOAD: begin
            next_st.dout_n = ~src_byte;
            next_st.par_n = ~dhp_pkg::odd_par(src_byte); // R7
            next_st.oe_n = 1'b0; // R10
            next_st.hs = dhp_pkg::HS_REQ;
          end
          dhp_pkg::HS_REQ: begin
            next_st.req_n = 1'b0; // R15
            next_st.hs = dhp_pkg::HS_ACK;
          end
          dhp_pkg::HS_ACK: begin
            if (ack) begin
              next_st.req_n = 1'b1; // R26
              next_st.hs = dhp_pkg::HS_REL;
            end
          end
          dhp_pkg::HS_REL: ;
          default: next_st.hs = dhp_pkg::HS_PREP;
        endcase
      end
      case (st.state)
        dhp_pkg::ST_IDLE: begin
          if (sel && din[SEL_ID_BIT]) begin
            next_st.busy_n = 1'b0; // R12
            next_st.par_err = 1'b0;
            next_st.exe_err = 1'b0;
            next_st.state = dhp_pkg::ST_SELECT; // R1
          end
        end
        dhp_pkg::ST_SELECT: begin
          // Wait for the host to drop select before using the bus
          if (!sel) begin
            next_st.cd_n = 1'b0; // R14
            next_st.io_n = 1'b1;
            next_st.cnt = 8'h00;
            next_st.cmd_len = dhp_pkg::CMD_LEN_SHORT;
            next_st.hs = dhp_pkg::HS_REQ;
            next_st.state = dhp_pkg::ST_CMD;
          end
        end
        dhp_pkg::ST_CMD: begin
          if (hs_cap) begin
            if (rx_par_bad) begin
              next_st.par_err = 1'b1; // R8
            end
            case (st.cnt)
              8'h00: begin
                next_st.op = din;
                next_st.cmd_len = (din[dhp_pkg::CLASS_MSB:dhp_pkg::CLASS_LSB] == dhp_pkg::CLASS_COPY) ?
                                  dhp_pkg::CMD_LEN_LONG : dhp_pkg::CMD_LEN_SHORT; // R25
              end
              8'h01: next_st.b1 = din;
              8'h02: next_st.b2 = din;
              8'h03: next_st.b3 = din;
              8'h04: next_st.blk = din;
              default: ;
            endcase
          end
          if (hs_end) begin
            next_st.cnt = st.cnt + 8'h01;
            next_st.hs = dhp_pkg::HS_REQ;
            if ((st.cnt + 8'h01) == {4'h0, st.cmd_len}) begin
              next_st.cmd_start = 1'b1; // R2
              next_st.state = dhp_pkg::ST_EXEC;
            end
          end
        end
        dhp_pkg::ST_EXEC: begin
          next_st.cnt = 8'h00;
          next_st.blk_left = st.blk;
          if (is_data) begin
            if (out_of_range || st.blk == 8'h00) begin
              next_st.exe_err = st.exe_err | out_of_range; // R3
              next_st.io_n = 1'b0;
              next_st.cd_n = 1'b0;
              next_st.hs = dhp_pkg::HS_PREP;
              next_st.state = dhp_pkg::ST_STATUS;
            end else if (st.op[4:0] == dhp_pkg::OP_READ) begin
              next_st.cd_n = 1'b1; // R11
              next_st.rx_ready = 1'b1;
              next_st.state = dhp_pkg::ST_DISK_IN;
            end else begin
              next_st.cd_n = 1'b1; // R11
              next_st.hs = dhp_pkg::HS_REQ;
              next_st.state = dhp_pkg::ST_HOST_IN;
            end
          end else if (exec_done_i) begin
            next_st.io_n = 1'b0;
            next_st.cd_n = 1'b0;
            next_st.hs = dhp_pkg::HS_PREP;
            next_st.state = dhp_pkg::ST_STATUS;
          end
        end
        dhp_pkg::ST_HOST_IN: begin
          if (hs_cap) begin
            if (rx_par_bad) begin
              next_st.par_err = 1'b1; // R8
            end
            next_st.wr_en = 1'b1; // R4
            next_st.wr_addr = st.cnt;
            next_st.wr_data = din;
          end
          if (hs_end) begin
            next_st.hs = dhp_pkg::HS_REQ;
            if (st.cnt == dhp_pkg::SECTOR_LAST) begin
              next_st.cnt = 8'h00; // R5
              next_st.hs = dhp_pkg::HS_PREP;
              next_st.state = dhp_pkg::ST_DISK_OUT;
            end else begin
              next_st.cnt = st.cnt + 8'h01;
            end
          end
        end
        dhp_pkg::ST_DISK_OUT: begin
          // Registered buffer read: address one cycle, data the next
          case (st.hs)
            dhp_pkg::HS_PREP: next_st.hs = dhp_pkg::HS_LOAD;
            dhp_pkg::HS_LOAD: begin
              next_st.tx_data = buf_if.rd_data;
              next_st.tx_valid = 1'b1;
              next_st.hs = dhp_pkg::HS_ACK;
            end
            default: begin
              if (disk_tx_ready_i) begin
                next_st.tx_valid = 1'b0;
                next_st.hs = dhp_pkg::HS_PREP;
                next_st.cnt = st.cnt + 8'h01;
                if (st.cnt == dhp_pkg::SECTOR_LAST) begin
                  next_st.blk_left = st.blk_left - 8'h01; // R5
                  next_st.cnt = 8'h00;
                  if (st.blk_left == 8'h01) begin
                    next_st.io_n = 1'b0;
                    next_st.cd_n = 1'b0;
                    next_st.state = dhp_pkg::ST_STATUS;
                  end else begin
                    next_st.hs = dhp_pkg::HS_REQ;
                    next_st.state = dhp_pkg::ST_HOST_IN;
                  end
                end
              end
            end
          endcase
        end
        dhp_pkg::ST_DISK_IN: begin
          if (disk_rx_valid_i && st.rx_ready) begin
            next_st.wr_en = 1'b1; // R4
            next_st.wr_addr = st.cnt;
            next_st.wr_data = disk_rx_data_i;
            next_st.cnt = st.cnt + 8'h01;
            if (st.cnt == dhp_pkg::SECTOR_LAST) begin
              next_st.rx_ready = 1'b0; // R5
              next_st.cnt = 8'h00;
              next_st.io_n = 1'b0; // R14
              next_st.hs = dhp_pkg::HS_PREP;
              next_st.state = dhp_pkg::ST_HOST_OUT;
            end
          end
        end
        dhp_pkg::ST_HOST_OUT: begin
          if (hs_end) begin
            next_st.hs = dhp_pkg::HS_PREP;
            next_st.cnt = st.cnt + 8'h01;
            if (st.cnt == dhp_pkg::SECTOR_LAST) begin
              next_st.blk_left = st.blk_left - 8'h01;
              next_st.cnt = 8'h00;
              if (st.blk_left == 8'h01) begin
                next_st.cd_n = 1'b0;
                next_st.state = dhp_pkg::ST_STATUS;
              end else begin
                // Turn the bus round before the disk refills the buffer
                next_st.io_n = 1'b1;
                next_st.oe_n = 1'b1;
                next_st.rx_ready = 1'b1;
                next_st.state = dhp_pkg::ST_DISK_IN;
              end
            end
          end
        end
        dhp_pkg::ST_STATUS: begin
          if (hs_end) begin
            next_st.err_pending = st.par_err | st.exe_err; // R6
            next_st.msg_n = 1'b0; // R13
            next_st.hs = dhp_pkg::HS_PREP;
            next_st.state = dhp_pkg::ST_DONE;
          end
        end
        dhp_pkg::ST_DONE: begin
          if (hs_cap) begin
            // Acknowledge of the done message frees every line at once
            next_st.busy_n = 1'b1; // R23
            next_st.io_n = 1'b1;
            next_st.cd_n = 1'b1;
            next_st.msg_n = 1'b1;
            next_st.oe_n = 1'b1;
            next_st.dout_n = 8'hFF;
            next_st.par_n = 1'b1;
            next_st.hs = dhp_pkg::HS_PREP;
            next_st.state = dhp_pkg::ST_IDLE;
          end
        end
        default: next_st.state = dhp_pkg::ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign host_busy_n_o = st.busy_n;
  assign host_io_n_o = st.io_n;
  assign host_cd_n_o = st.cd_n;
  assign host_msg_n_o = st.msg_n;
  assign host_req_n_o = st.req_n;
  assign host_data_o = st.dout_n;
  assign host_par_o = st.par_n;
  assign host_data_oe_n_o = st.oe_n;
  assign cmd_start_o = st.cmd_start;
  assign cmd_opcode_o = st.op;
  assign cmd_lun_o = st.b1[7:5];
  assign cmd_lba_o = {st.b1[4:0], st.b2, st.b3};
  assign cmd_nblk_o = st.blk;
  assign err_pending_o = st.err_pending;
  assign disk_tx_data_o = st.tx_data;
  assign disk_tx_valid_o = st.tx_valid;
  assign disk_rx_ready_o = st.rx_ready;

  // Checks
  localparam int BUSY_LIM = dhp_pkg::BUSY_MAX_CYC;
  logic [3:0] hlp_cmd_cnt;

  // Counts command bytes taken in the current command
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hlp_cmd_cnt <= 4'h0;
    end else if (st.state == dhp_pkg::ST_IDLE) begin
      hlp_cmd_cnt <= 4'h0;
    end else if (st.state == dhp_pkg::ST_CMD && hs_cap) begin
      hlp_cmd_cnt <= hlp_cmd_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_busy_on_select;
    (st.state == dhp_pkg::ST_IDLE && sel && din[SEL_ID_BIT] && !hrst) |-> ##[1:BUSY_LIM] !host_busy_n_o;
  endproperty
  a_busy_on_select: assert property (p_busy_on_select) else $error("busy late after select"); // R21

  property p_msg_with_dir;
    !host_msg_n_o |-> (!host_io_n_o && !host_cd_n_o && !host_busy_n_o);
  endproperty
  a_msg_with_dir: assert property (p_msg_with_dir) else $error("message without direction"); // R13

  property p_cmd_phase;
    (st.state == dhp_pkg::ST_CMD) |-> (host_io_n_o && !host_cd_n_o && host_msg_n_o && !host_busy_n_o);
  endproperty
  a_cmd_phase: assert property (p_cmd_phase) else $error("wrong command phase lines"); // R14

  property p_odd_parity;
    !host_data_oe_n_o |-> (^{~host_data_o, ~host_par_o}) == 1'b1;
  endproperty
  a_odd_parity: assert property (p_odd_parity) else $error("driven byte not odd parity"); // R7

  property p_drive_only_out;
    !host_data_oe_n_o |-> !host_io_n_o;
  endproperty
  a_drive_only_out: assert property (p_drive_only_out) else $error("driving data while host drives"); // R10

  property p_req_interlock;
    disable iff (!arst_n_i || hrst) $rose(host_req_n_o) |-> $past(ack);
  endproperty
  a_req_interlock: assert property (p_req_interlock) else $error("request dropped without ack"); // R26

  property p_cmd_len;
    cmd_start_o |-> hlp_cmd_cnt == ((st.op[7:5] == dhp_pkg::CLASS_COPY) ? 4'hA : 4'h6);
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("wrong command byte count"); // R25

  property p_data_cd;
    (st.state == dhp_pkg::ST_HOST_IN || st.state == dhp_pkg::ST_HOST_OUT) |-> host_cd_n_o;
  endproperty
  a_data_cd: assert property (p_data_cd) else $error("command line set in data phase"); // R11

  property p_host_reset;
    hrst |=> (!disk_tx_valid_o && !disk_rx_ready_o && host_busy_n_o && host_req_n_o && !err_pending_o);
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("outputs not released by reset"); // R17

  property p_status_spare;
    (st.state == dhp_pkg::ST_STATUS && st.hs >= dhp_pkg::HS_REQ && !host_data_oe_n_o) |-> host_data_o[4:2] == 3'h7;
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("status spare bits not zero"); // R24

  property p_range_err;
    (st.state == dhp_pkg::ST_EXEC && is_data && out_of_range && !hrst) |=> st.exe_err;
  endproperty
  a_range_err: assert property (p_range_err) else $error("range error not flagged"); // R3

  c_cmd_done: cover property (st.state == dhp_pkg::ST_DONE && hs_cap);
  c_read_sector: cover property (st.state == dhp_pkg::ST_HOST_OUT && hs_end && st.cnt == 8'hFF);
  c_write_sector: cover property (st.state == dhp_pkg::ST_DISK_OUT && disk_tx_ready_i && st.cnt == 8'hFF);
  c_par_err: cover property ($rose(st.par_err));

endmodule : dhp_host_port

// ---- verif/dhp_host_model.sv ----
`timescale 1ns/1ps
// Host adapter; open collector, so FF means released
module dhp_host_model (
  // Clock
  input wire logic clk_i,
  // Controller lines, pin levels
  input wire logic req_n_i,
  input wire logic io_n_i,
  input wire logic cd_n_i,
  input wire logic msg_n_i,
  input wire logic busy_n_i,
  input wire logic [7:0] bus_i,
  input wire logic par_i,
  // Host lines, pin levels
  output logic ack_n_o = 1'b1,
  output logic sel_n_o = 1'b1,
  output logic [7:0] data_o = 8'hFF,
  output logic par_o = 1'b1
);
  logic [7:0] cmd [10];
  logic [7:0] stat;
  logic [7:0] msgb;
  logic [7:0] b;
  logic bad = 1'b0;
  logic par_ok;
  logic done;
  logic [7:0] dlast;
  int got_n = 0;
  int n;
  int bcyc;
  // Interlocked handshake; data goes up with ack, both cross the same sync
  always @(posedge clk_i) begin
    b = cd_n_i ? 8'(n) : cmd[n];
    if (!req_n_i && ack_n_o) begin
      ack_n_o <= 1'b0;
      if (!io_n_i) begin
        if (!msg_n_i) msgb <= ~bus_i;
        else if (cd_n_i) begin
          dlast <= ~bus_i;
          got_n <= got_n + 1;
        end else stat <= ~bus_i;
        done <= !msg_n_i;
        par_ok <= par_ok & ~(^{bus_i, par_i});
      end else begin
        data_o <= ~b;
        par_o <= ^b ^ bad;
        n <= n + 1;
      end
    end else if (req_n_i && !ack_n_o) begin
      ack_n_o <= 1'b1;
      data_o <= 8'hFF;
      par_o <= 1'b1;
    end
  end
  // Select with the ID bit, released once busy answers
  task automatic select();
    sel_n_o <= 1'b0;
    data_o <= 8'hFE;
    for (bcyc = 0; bcyc < 40 && busy_n_i; bcyc++) @(posedge clk_i);
    sel_n_o <= 1'b1;
    data_o <= 8'hFF;
  endtask : select
endmodule : dhp_host_model

// ---- verif/disk_ctrl_host_bus_port_tb.sv ----
`timescale 1ns/1ps
module disk_ctrl_host_bus_port_tb;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic host_rst_n_i = 1'b1;
  logic parity_en_i = 1'b1;
  logic exec_done_i = 1'b0;
  logic exec_err_i = 1'b0;
  logic err_go = 1'b0;
  logic [20:0] max_lba_i = 21'h000064;
  wire busy_n, io_n, cd_n, msg_n, req_n, ack_n, sel_n, par_d, par_h, oe_n, start, err_p, tx_v, rx_rdy;
  wire [7:0] dat_d, dat_h, opc, nblk, tx_d;
  wire [2:0] logical_unit_number;
  wire [20:0] lba;
  // Wired-AND bus with pull-ups
  wire [7:0] bus = (oe_n ? 8'hFF : dat_d) & dat_h;
  wire bpar = (oe_n | par_d) & par_h;
  int fails = 0;
  int total_checks = 0;
  int tx_n = 0;
  int rx_taken = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  // Execution stand-in: done one cycle after hand-off; disk source counts bytes taken
  always @(posedge clk_sys_i) begin
    exec_done_i <= start;
    exec_err_i <= start & err_go;
    if (rx_rdy) rx_taken <= rx_taken + 1;
  end
  dhp_host_port dhp_host_port_i (.clk_sys_i, .arst_n_i, .host_sel_n_i(sel_n), .host_ack_n_i(ack_n),
    .host_rst_n_i, .host_busy_n_o(busy_n), .host_io_n_o(io_n), .host_cd_n_o(cd_n), .host_msg_n_o(msg_n),
    .host_req_n_o(req_n), .host_data_i(bus), .host_par_i(bpar), .host_data_o(dat_d), .host_par_o(par_d),
    .host_data_oe_n_o(oe_n), .parity_en_i, .max_lba_i, .cmd_start_o(start), .cmd_opcode_o(opc),
    .cmd_lun_o(logical_unit_number), .cmd_lba_o(lba), .cmd_nblk_o(nblk), .exec_done_i, .exec_err_i, .err_pending_o(err_p),
    .disk_tx_data_o(tx_d), .disk_tx_valid_o(tx_v), .disk_tx_ready_i(1'b1), .disk_rx_data_i(8'(rx_taken)),
    .disk_rx_valid_i(1'b1), .disk_rx_ready_o(rx_rdy));
  dhp_host_model dhp_host_model_i (.clk_i(clk_sys_i), .req_n_i(req_n), .io_n_i(io_n), .cd_n_i(cd_n),
    .msg_n_i(msg_n), .busy_n_i(busy_n), .bus_i(bus), .par_i(bpar), .ack_n_o(ack_n), .sel_n_o(sel_n),
    .data_o(dat_h), .par_o(par_h));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Disk sink: every byte must be the host byte that went into the buffer
  always @(negedge clk_sys_i) begin
    if (tx_v) begin
      chk(tx_d, 8'(tx_n + 6));
      tx_n <= tx_n + 1;
    end
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // One whole command through to the done message
  task automatic run(input int nb, input logic [7:0] st);
    int k;
    dhp_host_model_i.n = 0;
    dhp_host_model_i.done = 1'b0;
    dhp_host_model_i.par_ok = 1'b1;
    dhp_host_model_i.select();
    chk(8'(dhp_host_model_i.bcyc <= dhp_pkg::BUSY_MAX_CYC), 8'h01);
    for (k = 0; k < 8000 && !dhp_host_model_i.done; k++) @(posedge clk_sys_i);
    repeat (6) @(posedge clk_sys_i);
    chk(8'(dhp_host_model_i.n), 8'(nb));
    chk(dhp_host_model_i.stat, st);
    chk(dhp_host_model_i.msgb, 8'h00);
    chk({7'h00, dhp_host_model_i.par_ok}, 8'h01);
    chk({7'h00, busy_n}, 8'h01);
  endtask : run
  // Six bytes, bad parity ignored while checking is off
  task automatic t_short();
    dhp_host_model_i.cmd = '{1: 8'h60, default: 8'h00};
    dhp_host_model_i.bad = 1'b1;
    parity_en_i <= 1'b0;
    run(6, 8'h60);
    chk(opc, 8'h00);
  endtask : t_short
  // Ten-byte copy with an execution fault, lost after host reset
  task automatic t_copy();
    dhp_host_model_i.cmd = '{0: 8'h20, 1: 8'hA0, default: 8'h00};
    dhp_host_model_i.bad = 1'b0;
    parity_en_i <= 1'b1;
    err_go <= 1'b1;
    run(10, 8'hA2);
    chk({7'h00, err_p}, 8'h01);
    err_go <= 1'b0;
    host_rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    host_rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk({7'h00, err_p}, 8'h00);
  endtask : t_copy
  // Read past the limit with bad parity: no data phase
  task automatic t_range();
    dhp_host_model_i.cmd = '{0: 8'h08, 1: 8'h40, 3: 8'h65, 4: 8'h01, default: 8'h00};
    dhp_host_model_i.bad = 1'b1;
    run(6, 8'h43);
    chk(lba[7:0], 8'h65);
    chk(nblk, 8'h01);
    chk({5'h00, logical_unit_number}, 8'h02);
  endtask : t_range
  // One-block write through the buffer to the disk
  task automatic t_write();
    dhp_host_model_i.cmd = '{0: 8'h0A, 1: 8'h20, 3: 8'h10, 4: 8'h01, default: 8'h00};
    dhp_host_model_i.bad = 1'b0;
    run(262, 8'h20);
    chk(8'(tx_n == dhp_pkg::SECTOR_BYTES), 8'h01);
  endtask : t_write
  // One-block read from the disk back to the host
  task automatic t_read();
    dhp_host_model_i.cmd = '{0: 8'h08, 1: 8'hE0, 3: 8'h05, 4: 8'h01, default: 8'h00};
    run(6, 8'hE0);
    chk(8'(rx_taken == dhp_pkg::SECTOR_BYTES), 8'h01);
    chk(8'(dhp_host_model_i.got_n == dhp_pkg::SECTOR_BYTES), 8'h01);
    chk(dhp_host_model_i.dlast, 8'hFF);
  endtask : t_read
  initial begin
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_short();
    t_copy();
    t_write();
    t_read();
    t_range();
    wrap_up();
  end
  // Watchdog: the whole run needs about a third of this
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule : disk_ctrl_host_bus_port_tb
